// >>> logic/i2cs_hs.sv
// Toggle crossing of an event with a word held stable beside it
`timescale 1ns/10ps
module i2cs_hs #(
    parameter int W = 8
) (
    input  wire logic         src_clk,    // Source clock
    input  wire logic         src_reset,  // Source reset, active high
    input  wire logic         src_pulse,  // Event, one cycle
    input  wire logic [W-1:0] src_data,   // Word with the event
    input  wire logic         dst_clk,    // Destination clock
    input  wire logic         dst_reset,  // Destination reset, active high
    output logic              dst_pulse,  // Event, one cycle
    output logic      [W-1:0] dst_data    // Word, held until next event
);
    logic         tog;
    logic         next_tog;
    logic [W-1:0] hold;
    logic [W-1:0] next_hold;
    logic         tog_s;
    logic         tog_q;
    logic         next_tog_q;
    logic         next_dst_pulse;
    logic [W-1:0] next_dst_data;

    always_comb begin
        next_tog  = src_reset ? 1'b0 : (tog ^ src_pulse);
        next_hold = src_reset ? '0 : (src_pulse ? src_data : hold);
    end

    always_ff @(posedge src_clk) begin
        tog  <= next_tog;
        hold <= next_hold;
    end

    i2cs_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
        .clk (dst_clk),
        .rst (dst_reset),
        .d   (tog),
        .q   (tog_s)
    );

    // Word is stable for at least two destination cycles before the toggle lands
    always_comb begin
        next_tog_q     = dst_reset ? 1'b0 : tog_s;
        next_dst_pulse = dst_reset ? 1'b0 : (tog_s ^ tog_q);
        next_dst_data  = dst_reset ? '0 : ((tog_s ^ tog_q) ? hold : dst_data);
    end

    always_ff @(posedge dst_clk) begin
        tog_q     <= next_tog_q;
        dst_pulse <= next_dst_pulse;
        dst_data  <= next_dst_data;
    end
endmodule

// >>> logic/i2cs_map.svh
// Constant map of the two-wire slave register port
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH

`define I2CS_DEV_ADDR   7'h2E
`define I2CS_FIFO_BASE  8'h80
`define I2CS_BYTE_BITS  4'h8
`define I2CS_CNT_ZERO   4'h0
`define I2CS_CNT_FIRST  4'h1
`define I2CS_BYTE_ZERO  8'h00
`define I2CS_PIN_IDLE   3'h6

`endif

// >>> logic/i2cs_pkg.sv
// Types shared by the two-wire slave register port
package i2cs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } i2cs_state_e;

    typedef enum logic [1:0] {
        PH_DEV,
        PH_REG,
        PH_DATA
    } i2cs_phase_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } i2cs_acc_s;

endpackage

// >>> logic/i2cs_port.sv
// Two-wire slave port giving a bus master byte access to registers and FIFOs
// Contract
// RULE_01: Slave only; clock line is input only
// RULE_02: Data line driven low only, open drain
// RULE_03: Answer only to seven-bit address 0101110
// RULE_04: Eight-bit bytes, most significant bit first
// RULE_05: Receiver acknowledges in ninth clock period
// RULE_06: Master starts, clocks and stops every transfer
// RULE_07: Data changes only while clock low
// RULE_08: Start is data falling, clock high
// RULE_09: Stop is data rising, clock high
// RULE_10: Acknowledge received bytes by pulling data low
// RULE_11: Master releases data during device acknowledge
// RULE_12: Refused byte left undriven; master then stops
// RULE_13: Registers one byte; FIFOs many bytes
// RULE_14: Write: address, target, data, each acknowledged
// RULE_15: Every data byte of multi-byte write acknowledged
// RULE_16: Read: target write, repeated start, read
// RULE_17: Master acknowledges all read bytes but last
// RULE_18: Works at 100 and 400 kbps
// RULE_19: Wrong address: no acknowledge, wait start
// RULE_20: Target kept across repeated start
// RULE_21: FIFO target kept, one entry per byte
`timescale 1ns/10ps
`include "i2cs_map.svh"
module i2cs_port (
    input  wire logic              clk_sys,    // System clock
    input  wire logic              reset,      // Synchronous reset, active high
    input  wire logic              clk_link,   // Oversampling clock of the bus side
    input  wire logic              scl_i,      // Serial clock pin
    input  wire logic              sda_i,      // Serial data pin level
    output logic                   sda_o,      // Serial data drive value, always low
    output logic                   sda_oe,     // Serial data pulled low while high
    input  wire logic              accept_ok,  // Target can take a written byte
    input  wire logic              rd_valid,   // Read data answer, one cycle
    input  wire logic [7:0]        rd_data,    // Read data byte
    output logic                   acc_valid,  // Access request, one cycle
    output i2cs_pkg::i2cs_acc_s    acc         // Access kind, target and data
);
    import i2cs_pkg::*;

    logic             link_reset;
    logic [2:0]       pins_s;
    logic             scl_s;
    logic             sda_s;
    logic             accept_s;
    logic             scl_q;
    logic             sda_q;
    logic             scl_rise;
    logic             scl_fall;
    logic             start;
    logic             stop;
    i2cs_state_e      st;
    i2cs_state_e      next_st;
    i2cs_phase_e      ph;
    i2cs_phase_e      next_ph;
    logic [3:0]       cnt;
    logic [3:0]       next_cnt;
    logic [7:0]       sh;
    logic [7:0]       next_sh;
    logic [7:0]       txsh;
    logic [7:0]       next_txsh;
    logic [7:0]       tgt;
    logic [7:0]       next_tgt;
    logic [7:0]       rdbuf;
    logic [7:0]       next_rdbuf;
    logic             rw;
    logic             next_rw;
    logic             ack;
    logic             next_ack;
    logic             nbyte;
    logic             next_nbyte;
    logic             next_oe;
    logic             req_pulse;
    logic             next_req_pulse;
    i2cs_acc_s        ev;
    i2cs_acc_s        next_ev;
    logic             next_scl_q;
    logic             next_sda_q;
    logic             rd_arrive;
    logic [7:0]       rd_word;

    function automatic logic is_fifo(input logic [7:0] a);
        is_fifo = (a >= `I2CS_FIFO_BASE);
    endfunction

    // Reset brought into the bus-side domain
    i2cs_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
        .clk (clk_link),
        .rst (1'b0),
        .d   (reset),
        .q   (link_reset)
    );

    // RULE_18 pins oversampled fast
    i2cs_sync #(.W(3), .INIT(`I2CS_PIN_IDLE)) u_pin_sync (
        .clk (clk_link),
        .rst (link_reset),
        .d   ({scl_i, sda_i, accept_ok}),
        .q   (pins_s)
    );

    // RULE_01 clock only sampled
    assign scl_s    = pins_s[2];
    assign sda_s    = pins_s[1];
    assign accept_s = pins_s[0];
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    // RULE_08 start detection
    assign start    = scl_s & scl_q & sda_q & ~sda_s;
    // RULE_09 stop detection
    assign stop     = scl_s & scl_q & ~sda_q & sda_s;

    always_comb begin
        next_st        = st;
        next_ph        = ph;
        next_cnt       = cnt;
        next_sh        = sh;
        next_txsh      = txsh;
        next_tgt       = tgt;
        next_rw        = rw;
        next_ack       = ack;
        next_nbyte     = nbyte;
        next_oe        = sda_oe;
        next_req_pulse = 1'b0;
        next_ev        = ev;
        next_scl_q     = scl_s;
        next_sda_q     = sda_s;
        next_rdbuf     = rd_arrive ? rd_word : rdbuf;
        if (start) begin
            // RULE_20 target survives a repeated start
            next_st  = ST_RX;
            next_ph  = PH_DEV;
            next_cnt = `I2CS_CNT_ZERO;
            next_oe  = 1'b0;
        end else if (stop) begin
            next_st  = ST_IDLE;
            next_cnt = `I2CS_CNT_ZERO;
            next_oe  = 1'b0;
        end else begin
            case (st)
                ST_RX: begin
                    if (scl_rise && (cnt < `I2CS_BYTE_BITS)) begin
                        // RULE_04 shift in, first bit ends on top
                        next_sh  = {sh[6:0], sda_s};
                        next_cnt = cnt + `I2CS_CNT_FIRST;
                    end else if (scl_fall && (cnt == `I2CS_BYTE_BITS)) begin
                        // RULE_05 answer in the ninth period
                        next_cnt = `I2CS_CNT_ZERO;
                        next_st  = ST_ACK;
                        case (ph)
                            PH_DEV: begin
                                // RULE_03 address compare
                                if (sh[7:1] == `I2CS_DEV_ADDR) begin
                                    // RULE_10 pull low for the acknowledge
                                    next_ack = 1'b1;
                                    next_oe  = 1'b1;
                                    next_rw  = sh[0];
                                    if (sh[0]) begin
                                        // RULE_16 fetch the byte while acknowledging
                                        next_req_pulse = 1'b1;
                                        next_ev        = '{wr: 1'b0, addr: tgt, data: `I2CS_BYTE_ZERO};
                                    end
                                end else begin
                                    // RULE_19 stay off the bus until the next start
                                    next_ack = 1'b0;
                                    next_oe  = 1'b0;
                                    next_st  = ST_IGNORE;
                                end
                            end
                            PH_REG: begin
                                // RULE_14 target byte taken and acknowledged
                                next_tgt   = sh;
                                next_nbyte = 1'b0;
                                next_ack   = 1'b1;
                                next_oe    = 1'b1;
                            end
                            PH_DATA: begin
                                // RULE_13 second byte to a register refused
                                // RULE_12 refused byte leaves the line released
                                if (accept_s && (is_fifo(tgt) || !nbyte)) begin
                                    // RULE_15 each written byte acknowledged
                                    next_ack       = 1'b1;
                                    next_oe        = 1'b1;
                                    next_nbyte     = 1'b1;
                                    next_req_pulse = 1'b1;
                                    next_ev        = '{wr: 1'b1, addr: tgt, data: sh};
                                end else begin
                                    next_ack = 1'b0;
                                    next_oe  = 1'b0;
                                end
                            end
                            default: begin
                                next_st = ST_IGNORE;
                                next_oe = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // RULE_07 drive changes only on a falling clock
                    if (scl_fall) begin
                        if (!ack) begin
                            next_st = ST_IGNORE;
                            next_oe = 1'b0;
                        end else if ((ph == PH_DEV) && rw) begin
                            // RULE_04 most significant bit goes out first
                            next_st   = ST_TX;
                            next_oe   = ~rdbuf[7];
                            next_txsh = {rdbuf[6:0], 1'b0};
                            next_cnt  = `I2CS_CNT_FIRST;
                        end else begin
                            // RULE_02 release after the acknowledge
                            next_st = ST_RX;
                            next_oe = 1'b0;
                            next_ph = (ph == PH_DEV) ? PH_REG : PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt < `I2CS_BYTE_BITS) begin
                            next_oe   = ~txsh[7];
                            next_txsh = {txsh[6:0], 1'b0};
                            next_cnt  = cnt + `I2CS_CNT_FIRST;
                        end else begin
                            // RULE_05 line freed for the master's answer
                            next_oe  = 1'b0;
                            next_cnt = `I2CS_CNT_ZERO;
                            next_st  = ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        // RULE_17 master acknowledge asks for one more byte
                        // RULE_21 same target, one entry per byte
                        if (!sda_s) begin
                            next_req_pulse = 1'b1;
                            next_ev        = '{wr: 1'b0, addr: tgt, data: `I2CS_BYTE_ZERO};
                            next_ack       = 1'b1;
                            next_st        = ST_ACK;
                        end else begin
                            next_st = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_oe = 1'b0;
                end
                default: begin
                    next_st = ST_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
        if (link_reset) begin
            next_st        = ST_IDLE;
            next_ph        = PH_DEV;
            next_cnt       = `I2CS_CNT_ZERO;
            next_sh        = `I2CS_BYTE_ZERO;
            next_txsh      = `I2CS_BYTE_ZERO;
            next_tgt       = `I2CS_BYTE_ZERO;
            next_rdbuf     = `I2CS_BYTE_ZERO;
            next_rw        = 1'b0;
            next_ack       = 1'b0;
            next_nbyte     = 1'b0;
            next_oe        = 1'b0;
            next_req_pulse = 1'b0;
            next_ev        = '0;
            next_scl_q     = 1'b1;
            next_sda_q     = 1'b1;
        end
    end

    always_ff @(posedge clk_link) begin
        st        <= next_st;
        ph        <= next_ph;
        cnt       <= next_cnt;
        sh        <= next_sh;
        txsh      <= next_txsh;
        tgt       <= next_tgt;
        rdbuf     <= next_rdbuf;
        rw        <= next_rw;
        ack       <= next_ack;
        nbyte     <= next_nbyte;
        sda_oe    <= next_oe;
        req_pulse <= next_req_pulse;
        ev        <= next_ev;
        scl_q     <= next_scl_q;
        sda_q     <= next_sda_q;
        sda_o     <= 1'b0;
    end

    // Access requests to the system side
    i2cs_hs #(.W($bits(i2cs_acc_s))) u_req_cross (
        .src_clk   (clk_link),
        .src_reset (link_reset),
        .src_pulse (req_pulse),
        .src_data  (ev),
        .dst_clk   (clk_sys),
        .dst_reset (reset),
        .dst_pulse (acc_valid),
        .dst_data  (acc)
    );

    // Read data back to the bus side
    i2cs_hs #(.W(8)) u_rd_cross (
        .src_clk   (clk_sys),
        .src_reset (reset),
        .src_pulse (rd_valid),
        .src_data  (rd_data),
        .dst_clk   (clk_link),
        .dst_reset (link_reset),
        .dst_pulse (rd_arrive),
        .dst_data  (rd_word)
    );

    a_oe_clock_low: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_07
        $changed(sda_oe) |-> !scl_s) else $error("data drive changed while clock high");
    a_start_to_addr: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_08
        start |=> (st == ST_RX) && (ph == PH_DEV) && (cnt == 4'h0) && !sda_oe)
        else $error("start did not begin an address byte");
    a_stop_to_idle: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_09
        stop |=> (st == ST_IDLE) && !sda_oe) else $error("stop did not free the bus");
    a_ack_on_match: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_10
        (st == ST_RX) && (ph == PH_DEV) && (cnt == 4'h8) && scl_fall && !start && !stop
        && (sh[7:1] == 7'h2E) |=> sda_oe && (st == ST_ACK))
        else $error("own address not acknowledged");
    a_nack_mismatch: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_19
        (st == ST_RX) && (ph == PH_DEV) && (cnt == 4'h8) && scl_fall && !start && !stop
        && (sh[7:1] != 7'h2E) |=> !sda_oe && (st == ST_IGNORE))
        else $error("foreign address acknowledged");
    a_shift_msb: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_04
        (st == ST_RX) && scl_rise && (cnt < 4'h8) && !start && !stop
        |=> (sh[0] == $past(sda_s)) && (sh[7:1] == $past(sh[6:0])))
        else $error("received bit not shifted in at the bottom");
    a_reg_single: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_13
        (st == ST_RX) && (ph == PH_DATA) && (cnt == 4'h8) && scl_fall && !start && !stop
        && nbyte && !is_fifo(tgt) |=> !sda_oe && !req_pulse)
        else $error("second register byte accepted");
    a_tx_first_bit: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_16
        (st == ST_ACK) && scl_fall && ack && rw && (ph == PH_DEV) && !start && !stop
        |=> (st == ST_TX) && (sda_oe == !$past(rdbuf[7])))
        else $error("read byte did not start with its top bit");
    a_target_hold: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_21
        (ph == PH_DATA) && (st != ST_IDLE) |=> $stable(tgt))
        else $error("target changed during data bytes");
    a_ignore_quiet: assert property (@(posedge clk_link) disable iff (link_reset) // RULE_12
        (st == ST_IGNORE) |-> !sda_oe && !req_pulse) else $error("bus touched while ignoring");
    a_req_one_cycle: assert property (@(posedge clk_sys) disable iff (reset) // RULE_14
        acc_valid |=> !acc_valid) else $error("access request longer than one cycle");

    c_write_byte: cover property (@(posedge clk_link) disable iff (link_reset)
        req_pulse && ev.wr);
    c_read_byte: cover property (@(posedge clk_link) disable iff (link_reset)
        (st == ST_TX) && (cnt == 4'h8));
    c_foreign: cover property (@(posedge clk_link) disable iff (link_reset)
        st == ST_IGNORE);
    c_multi_read: cover property (@(posedge clk_link) disable iff (link_reset)
        (st == ST_MACK) && scl_rise && !sda_s);
endmodule

// >>> logic/i2cs_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module i2cs_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk,   // Destination clock
    input  wire logic         rst,   // Synchronous reset, active high
    input  wire logic [W-1:0] d,     // Asynchronous level in
    output logic      [W-1:0] q      // Synchronised level out
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = rst ? INIT : d;
        next_q    = rst ? INIT : meta;
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q    <= next_q;
    end
endmodule

// >>> sim/i2cs_master.sv
// Behavioural two-wire bus master that drives the clock and the data line
`timescale 1ns/10ps
module i2cs_master (
    output logic     scl,      // Serial clock, master only
    output logic     sda_low,  // Pulls data line low while high
    input  wire logic sda      // Resolved data wire
);
    int half_ns = 1250;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        #(half_ns / 2) sda_low = 1'b0;
        #(half_ns / 2) scl = 1'b1;
        #(half_ns) sda_low = 1'b1;
        #(half_ns) scl = 1'b0;
    endtask

    task automatic stop();
        #(half_ns / 2) sda_low = 1'b1;
        #(half_ns / 2) scl = 1'b1;
        #(half_ns) sda_low = 1'b0;
        #(half_ns);
    endtask

    task automatic bit_io(input logic b, output logic r);
        #(half_ns / 2) sda_low = ~b;
        #(half_ns / 2) scl = 1'b1;
        #(half_ns / 2) r = sda;
        #(half_ns / 2) scl = 1'b0;
    endtask

    // msb first, line released for acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~more, r);
    endtask
endmodule

// >>> sim/tb_i2c_slave_register_port.sv
// Self-checking bench of the two-wire slave register port
`timescale 1ns/10ps
module tb_i2c_slave_register_port;
    import i2cs_pkg::*;
    // Rows: device byte, target, data, accept_ok, expected acks
    localparam logic [27:0] ROWS [3] = '{
        {8'h5C, 8'h10, 8'h3C, 1'b1, 3'b111},
        {8'h5C, 8'h11, 8'h5A, 1'b0, 3'b110},
        {8'h5E, 8'h10, 8'h3C, 1'b1, 3'b000}};
    logic       clk_sys = 1'b0;
    logic       clk_link = 1'b0;
    logic       reset = 1'b1;
    logic       accept_ok = 1'b1;
    logic       rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] rd_seq = 8'h00;
    logic       scl, sda_low, sda, sda_o, sda_oe, acc_valid;
    i2cs_acc_s  acc;
    i2cs_acc_s  accq[$];
    int         failures = 0;
    int         total_checks = 0;

    always #5 clk_sys = ~clk_sys;
    initial begin
        #1.7;
        forever #3 clk_link = ~clk_link;
    end

    assign sda = (sda_low || sda_oe === 1'b1) ? 1'b0 : 1'b1;

    i2cs_port i_i2cs_port (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .accept_ok(accept_ok), .rd_valid(rd_valid), .rd_data(rd_data),
        .acc_valid(acc_valid), .acc(acc));
    i2cs_master i_i2cs_master (.scl(scl), .sda_low(sda_low), .sda(sda));

    // Answers every read request one cycle later and logs all requests
    always @(posedge clk_sys) begin
        rd_valid <= (acc_valid === 1'b1) && (acc.wr === 1'b0);
        rd_data <= acc.addr + rd_seq;
        if (acc_valid === 1'b1) begin
            accq.push_back(acc);
        end
        if (acc_valid === 1'b1 && acc.wr === 1'b0) begin
            rd_seq <= rd_seq + 8'h01;
        end
    end

    task automatic check_ack(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected byte at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_acc(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        i2cs_acc_s got;
        total_checks++;
        got = (accq.size() > 0) ? accq.pop_front() : 'x;
        if ({got.wr, got.addr} !== {wr, addr} || (wr && got.data !== data)) begin
            failures++;
            $display("unexpected access at %0t: got %h", $time, got);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp, output logic ack);
        i_i2cs_master.wbyte(b, ack);
        check_ack(ack, exp);
    endtask

    task automatic write_burst(input logic [7:0] tgt, input logic [7:0] d0, input int n, input logic last);
        logic ok;
        i_i2cs_master.start();
        send(8'h5C, 1'b1, ok);
        send(tgt, 1'b1, ok);
        for (int j = 0; j < n; j++) begin
            send(d0 + 8'(j), (j < n - 1) || last, ok);
        end
        i_i2cs_master.stop();
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // device data edges only while clock low
    always @(sda_oe) begin
        if (reset === 1'b0) check_ack(scl, 1'b0);
    end

    initial begin
        logic        ok;
        logic [7:0]  d;
        logic [27:0] r;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check_ack(sda_oe, 1'b0);
        check_ack(sda_o, 1'b0);
        for (int i = 0; i < 3; i++) begin
            r = ROWS[i];
            accept_ok <= r[3];
            @(posedge clk_sys);
            i_i2cs_master.start();
            send(r[27:20], r[2], ok);
            if (ok) send(r[19:12], r[1], ok);
            if (ok) send(r[11:4], r[0], ok);
            i_i2cs_master.stop();
            repeat (20) @(posedge clk_sys);
            if (r[2:0] == 3'b111) check_acc(1'b1, r[19:12], r[11:4]);
        end
        check_ack(accq.size() == 0, 1'b1);
        accept_ok <= 1'b1;
        write_burst(8'h81, 8'hA1, 2, 1'b1);
        check_acc(1'b1, 8'h81, 8'hA1);
        check_acc(1'b1, 8'h81, 8'hA2);
        write_burst(8'h20, 8'h77, 2, 1'b0);
        check_acc(1'b1, 8'h20, 8'h77);
        i_i2cs_master.start();
        send(8'h5C, 1'b1, ok);
        send(8'h83, 1'b1, ok);
        i_i2cs_master.start();
        send(8'h5D, 1'b1, ok);
        for (int k = 0; k < 3; k++) begin
            i_i2cs_master.rbyte(k < 2, d);
            check_byte(d, 8'h83 + 8'(k));
        end
        i_i2cs_master.stop();
        repeat (20) @(posedge clk_sys);
        for (int k = 0; k < 3; k++) begin
            check_acc(1'b0, 8'h83, 8'h00);
        end
        check_ack(accq.size() == 0, 1'b1);
        i_i2cs_master.half_ns = 5000;
        write_burst(8'h30, 8'h69, 1, 1'b1);
        check_acc(1'b1, 8'h30, 8'h69);
        print_verdict();
    end

    initial begin
        // Whole run takes about 830 us; this stays under 100000 system clocks
        #950_000;
        failures++;
        print_verdict();
    end
endmodule
